// >>> dca_pkg.sv
package dca_pkg;
    // --------------------------------------------------------------
    // Frame layout, counted in serial clock falling edges
    // --------------------------------------------------------------
    localparam int         RES_BITS_DEFAULT = 12;
    localparam logic [4:0] FRAME_BITS       = 5'h10;
    localparam logic [4:0] LEAD_ZEROS       = 5'h02;
    localparam logic [4:0] ID_POS           = 5'h02;
    localparam logic [4:0] MODE_POS         = 5'h03;
    localparam logic [4:0] DATA_POS         = 5'h04;
    localparam logic [4:0] CHSEL_POS        = 5'h03;
    localparam logic       MODE_NORMAL      = 1'b0;
    localparam int         FIFO_DEPTH       = 16;

    // --------------------------------------------------------------
    // Timing
    // --------------------------------------------------------------
    localparam int CLK_PERIOD_NS              = 25;
    localparam int INTER_CONVERSION_GAP_NS    = 30;
    localparam int ACQUISITION_INTERVAL_NS    = 290;
    localparam int INTER_CONVERSION_GAP_CYC   =
        (INTER_CONVERSION_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACQUISITION_INTERVAL_CYC   =
        (ACQUISITION_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : dca_pkg

// >>> dca_fifo_if.sv
`timescale 1ns/1ps
interface dca_fifo_if #(
    parameter int W = 1
);
    logic         push_valid;
    logic         push_ready;
    logic [W-1:0] push_data;
    logic         pop_valid;
    logic         pop_ready;
    logic [W-1:0] pop_data;
    logic         flush;

    modport fifo (
        input  push_valid,
        output push_ready,
        input  push_data,
        output pop_valid,
        input  pop_ready,
        output pop_data,
        input  flush
    );
    modport user (
        output push_valid,
        input  push_ready,
        output push_data,
        input  pop_valid,
        output pop_ready,
        input  pop_data,
        output flush
    );
endinterface : dca_fifo_if

// >>> dca_fifo.sv
`timescale 1ns/1ps
module dca_fifo #(
    parameter int W     = 1,
    parameter int DEPTH = 16
) (
    input  wire logic ref_clk,
    input  wire logic reset_n,
    dca_fifo_if.fifo  f
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wr_ptr;
        logic [AW-1:0]           rd_ptr;
        logic [AW:0]             count;
    } dca_fifo_state_t;

    dca_fifo_state_t st;
    dca_fifo_state_t next_st;
    logic            do_push;
    logic            do_pop;

    assign f.push_ready = (st.count != (AW+1)'(DEPTH));
    assign f.pop_valid  = (st.count != '0);
    assign f.pop_data   = st.mem[st.rd_ptr];

    always_comb begin
        next_st = st;
        do_push = f.push_valid && f.push_ready;
        do_pop  = f.pop_valid && f.pop_ready;
        if (f.flush) begin
            next_st.wr_ptr = '0;
            next_st.rd_ptr = '0;
            next_st.count  = '0;
        end else begin
            if (do_push) begin
                next_st.mem[st.wr_ptr] = f.push_data;
                next_st.wr_ptr = AW'((st.wr_ptr + 1'b1) % DEPTH);
            end
            if (do_pop) begin
                next_st.rd_ptr = AW'((st.rd_ptr + 1'b1) % DEPTH);
            end
            if (do_push && !do_pop) begin
                next_st.count = st.count + 1'b1;
            end else if (do_pop && !do_push) begin
                next_st.count = st.count - 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule : dca_fifo

// >>> dca_serial_port.sv
// Overview of operation
// - Each frame bit after the first leaves on result_out after a serial clock falling edge.
// - 12-bit frame: two zeros, id, mode, 12 result bits MSB first.
// - 10-bit frame: two zeros, id, mode, 10 result bits, two trailing zeros.
// - Active low frame select starts conversion and frames the transfer.
// - The serial clock alone paces shifting and the successive approximation.
// - Channel select input is captured on a serial clock falling edge.
// - Third bit shifted in picks the analog input for the track-and-hold.
// - Conversion lasts 16 or 14 serial clock periods after frame start.
// - Fourth frame bit always reports normal mode.
// - Output driven after frame select, released after the last clock fall.
`timescale 1ns/1ps
module dca_serial_port #(
    parameter int RES = dca_pkg::RES_BITS_DEFAULT
) (
    input  wire logic           ref_clk,
    input  wire logic           reset_n,
    input  wire logic           frame_sel_n,
    input  wire logic           serial_clk,
    input  wire logic           chan_sel_in,
    input  wire logic           cmp_high,
    output logic                result_out,
    output logic                result_oe,
    output logic [RES-1:0]      dac_code,
    output logic                input_sel,
    output logic                hold
);
    localparam logic [4:0] DATA_END = 5'(dca_pkg::DATA_POS + RES);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0]     sclk_sy;
        logic [2:0]     cs_sy;
        logic [2:0]     din_sy;
        logic           sclk_st;
        logic           cs_st;
        logic           din_st;
        logic           active;
        logic [4:0]     fall_cnt;
        logic           oe;
        logic           dout;
        logic           chan_cur;
        logic           chan_next;
        logic           mux_sel;
        logic           hold;
        logic [RES-1:0] code;
    } dca_state_t;

    dca_state_t st;
    dca_state_t next_st;
    logic       fall;
    logic       cs_fall;
    logic       cs_rise;
    logic       evt;
    logic [4:0] n;
    int         k;
    logic       push_v;
    logic       push_d;
    logic       flush;

    dca_fifo_if #(.W(1)) bits_if ();

    dca_fifo #(
        .W     (1),
        .DEPTH (dca_pkg::FIFO_DEPTH)
    ) u_fifo (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .f       (bits_if.fifo)
    );

    assign bits_if.push_valid = push_v;
    assign bits_if.push_data  = push_d;
    assign bits_if.flush      = flush;
    assign bits_if.pop_ready  = st.oe;

    assign result_out = st.dout;
    assign result_oe  = st.oe;
    assign dac_code   = st.code;
    assign input_sel  = st.mux_sel;
    assign hold       = st.hold;

    // ------------------------------------------------------------------
    // Frame bit selection
    // ------------------------------------------------------------------
    function automatic logic frame_bit(input logic [4:0] pos,
                                       input logic       chan,
                                       input logic       cmp);
        logic b;
        b = 1'b0;
        if (pos == dca_pkg::ID_POS) begin
            b = chan;
        end else if (pos == dca_pkg::MODE_POS) begin
            b = dca_pkg::MODE_NORMAL;
        end else if (pos >= dca_pkg::DATA_POS && pos < DATA_END) begin
            b = cmp;
        end
        return b;
    endfunction : frame_bit

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;
        push_v  = 1'b0;
        push_d  = 1'b0;
        flush   = 1'b0;
        k       = 0;
        next_st.sclk_sy = {st.sclk_sy[1:0], serial_clk};
        next_st.cs_sy   = {st.cs_sy[1:0], frame_sel_n};
        next_st.din_sy  = {st.din_sy[1:0], chan_sel_in};
        if (st.sclk_sy[1] == st.sclk_sy[2]) begin
            next_st.sclk_st = st.sclk_sy[2];
        end
        if (st.cs_sy[1] == st.cs_sy[2]) begin
            next_st.cs_st = st.cs_sy[2];
        end
        if (st.din_sy[1] == st.din_sy[2]) begin
            next_st.din_st = st.din_sy[2];
        end
        fall    = st.sclk_st && !st.sclk_sy[1] && !st.sclk_sy[2];
        cs_fall = st.cs_st && !st.cs_sy[1] && !st.cs_sy[2];
        cs_rise = !st.cs_st && st.cs_sy[1] && st.cs_sy[2];
        // A falling edge seen while the buffer is full is dropped, so
        // the serial clock must not outrun the drain; depth covers a frame.
        evt     = fall && st.active && bits_if.push_ready;
        n       = st.fall_cnt + 5'h01;
        if (cs_rise) begin
            next_st.active = 1'b0;
            next_st.oe     = 1'b0;
            next_st.hold   = 1'b0;
            flush          = 1'b1;
        end else if (cs_fall) begin
            next_st.active   = 1'b1;
            next_st.fall_cnt = 5'h00;
            next_st.oe       = 1'b1;
            next_st.dout     = 1'b0;
            next_st.hold     = 1'b1;
            next_st.chan_cur = st.mux_sel;
            next_st.code     = '0;
        end else if (evt) begin
            next_st.fall_cnt = n;
            if (n == dca_pkg::FRAME_BITS) begin
                next_st.active = 1'b0;
                next_st.oe     = 1'b0;
            end else begin
                push_v = 1'b1;
                push_d = frame_bit(n, st.chan_cur, cmp_high);
            end
            if (n == dca_pkg::CHSEL_POS) begin
                next_st.chan_next = st.din_st;
            end
            if (n == dca_pkg::DATA_POS - 5'h01) begin
                next_st.code          = '0;
                next_st.code[RES-1]   = 1'b1;
            end
            if (n >= dca_pkg::DATA_POS && n < DATA_END) begin
                k = RES - 1 - int'(n - dca_pkg::DATA_POS);
                next_st.code[k] = cmp_high;
                if (k > 0) begin
                    next_st.code[k-1] = 1'b1;
                end
            end
            if (n == DATA_END) begin
                next_st.hold    = 1'b0;
                next_st.mux_sel = st.chan_next;
            end
        end
        if (st.oe && bits_if.pop_valid) begin
            next_st.dout = bits_if.pop_data;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st         <= '0;
            st.cs_sy   <= 3'h7;
            st.cs_st   <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    dout_on_pop_a: assert property (
        $changed(result_out)
            |-> $past(cs_fall || (st.oe && bits_if.pop_valid)))
        else $error("result_out changed without a frame bit");
    lead_zero_a: assert property (
        push_v && n < dca_pkg::LEAD_ZEROS |-> !push_d)
        else $error("leading bit not zero");
    trail_zero_a: assert property (
        push_v && n >= DATA_END |-> !push_d)
        else $error("trailing bit not zero");
    frame_start_a: assert property (
        cs_fall |=> st.active && result_oe && hold && st.fall_cnt == 5'h00)
        else $error("frame select did not start a frame");
    code_on_fall_a: assert property (
        $changed(dac_code) |-> $past(evt || cs_fall))
        else $error("trial code moved without a clock edge");
    chan_capture_a: assert property (
        $changed(st.chan_next) |-> $past(evt && n == dca_pkg::CHSEL_POS))
        else $error("channel select captured at wrong edge");
    mux_route_a: assert property (
        $changed(input_sel) |-> $past(evt && n == DATA_END)
            && input_sel == $past(st.chan_next))
        else $error("input routing changed at wrong time");
    conv_len_a: assert property (
        $fell(hold) |-> $past(cs_rise || (evt && n == DATA_END)))
        else $error("conversion length wrong");
    mode_bit_a: assert property (
        push_v && n == dca_pkg::MODE_POS |-> push_d == dca_pkg::MODE_NORMAL)
        else $error("mode bit wrong");
    release_a: assert property (
        $fell(result_oe) |-> $past(cs_rise
            || (evt && n == dca_pkg::FRAME_BITS)))
        else $error("output released at wrong time");
    chan_id_a: assert property (
        push_v && n == dca_pkg::ID_POS |-> push_d == st.chan_cur)
        else $error("channel id bit wrong");

    full_frame_c: cover property (evt && n == dca_pkg::FRAME_BITS);
    abort_c:      cover property (cs_rise && st.active);
    chan_one_c:   cover property (push_v && n == dca_pkg::ID_POS && push_d);
endmodule : dca_serial_port

// >>> dca_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host serial master
// ----------------------------------------------------------------
module dca_host_model (
    input  wire logic ref_clk,
    output logic      frame_sel_n,
    output logic      serial_clk,
    output logic      chan_sel_in,
    input  wire logic res12,
    input  wire logic oe12,
    input  wire logic res10,
    input  wire logic oe10,
    input  wire logic hold10
);
    // Slower than the pins need: the design resolves about four cycles.
    localparam int HALF = 6;

    initial begin
        frame_sel_n = 1'b1;
        serial_clk  = 1'b1;
        chan_sel_in = 1'b0;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : wait_cyc

    // A bit that is not driven is recorded as unknown, so it never matches.
    task automatic run_frame(input  logic        chan,
                             input  int          nf,
                             output logic [15:0] f12,
                             output logic [15:0] f10,
                             output logic [15:0] h10);
        f12 = 'x;
        f10 = 'x;
        h10 = 'x;
        frame_sel_n = 1'b0;
        chan_sel_in = ~chan;
        wait_cyc(8);
        for (int b = 0; b < nf; b++) begin
            f12[15-b]  = oe12 ? res12 : 1'bx;
            f10[15-b]  = oe10 ? res10 : 1'bx;
            h10[15-b]  = hold10;
            serial_clk = 1'b0;
            wait_cyc(HALF);
            serial_clk = 1'b1;
            chan_sel_in = (b == 1) ? chan : ~chan;
            wait_cyc(HALF);
        end
    endtask : run_frame

    task automatic end_frame();
        frame_sel_n = 1'b1;
        chan_sel_in = ~chan_sel_in;
        wait_cyc(12);
    endtask : end_frame

    task automatic stray_falls();
        repeat (3) begin
            serial_clk = 1'b0;
            wait_cyc(HALF);
            serial_clk = 1'b1;
            wait_cyc(HALF);
        end
    endtask : stray_falls
endmodule : dca_host_model

// >>> dca_serial_port_bench.sv
`timescale 1ns/1ps
module dca_serial_port_bench;
    logic        ref_clk, reset_n, frame_sel_n, serial_clk, chan_sel_in;
    logic [11:0] analog_input_zero, analog_input_one, dac12;
    logic [9:0]  dac10;
    logic        res12, oe12, sel12, hold12, cmp12;
    logic        res10, oe10, sel10, hold10, cmp10;
    logic [15:0] f12, f10, h10;
    int          failures, cmp_count, cycles;

    // ------------------------------------------------------------
    // Comparators and instances
    // ------------------------------------------------------------
    assign cmp12 = ((sel12 ? analog_input_one : analog_input_zero) >= dac12);
    assign cmp10 = ((sel10 ? analog_input_one[11:2]
                           : analog_input_zero[11:2]) >= dac10);

    dca_serial_port #(.RES(12)) u_dca_serial_port (
        .ref_clk(ref_clk), .reset_n(reset_n), .frame_sel_n(frame_sel_n),
        .serial_clk(serial_clk), .chan_sel_in(chan_sel_in),
        .cmp_high(cmp12), .result_out(res12), .result_oe(oe12),
        .dac_code(dac12), .input_sel(sel12), .hold(hold12));
    dca_serial_port #(.RES(10)) u_dca_serial_port_10 (
        .ref_clk(ref_clk), .reset_n(reset_n), .frame_sel_n(frame_sel_n),
        .serial_clk(serial_clk), .chan_sel_in(chan_sel_in),
        .cmp_high(cmp10), .result_out(res10), .result_oe(oe10),
        .dac_code(dac10), .input_sel(sel10), .hold(hold10));
    dca_host_model u_dca_host_model (
        .ref_clk(ref_clk), .frame_sel_n(frame_sel_n),
        .serial_clk(serial_clk), .chan_sel_in(chan_sel_in),
        .res12(res12), .oe12(oe12), .res10(res10), .oe10(oe10),
        .hold10(hold10));

    // ------------------------------------------------------------
    // Clock, checks and verdict
    // ------------------------------------------------------------
    initial ref_clk = 1'b0;
    always #12.5 ref_clk = ~ref_clk;

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp,
                         input string msg);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk16

    task automatic chk1(input logic got, input logic exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t %s got %b", $time, msg, got);
        end
    endtask : chk1

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : summarize

    // Generous ceiling: the whole sequence needs about 1200 cycles.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 4000) begin
            failures++;
            $display("MISMATCH t=%0t run did not finish", $time);
            summarize();
        end
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_frame(input logic chan, input logic id,
                           input logic [11:0] a, input logic [11:0] b);
        logic [11:0] v;
        logic [15:0] e12;
        logic [15:0] e10;
        analog_input_zero = a;
        analog_input_one  = b;
        v   = id ? b : a;
        e12 = {2'b00, id, dca_pkg::MODE_NORMAL, v};
        e10 = {2'b00, id, dca_pkg::MODE_NORMAL, v[11:2], 2'b00};
        u_dca_host_model.run_frame(chan, 16, f12, f10, h10);
        chk16(f12, e12, "frame12");
        chk16(f10, e10, "frame10");
        chk16(h10, 16'hFFFC, "hold10");
        chk16({4'h0, dac12}, {4'h0, v}, "dac12");
        chk16({6'h00, dac10}, {6'h00, v[11:2]}, "dac10");
        chk1(sel12, chan, "sel12");
        chk1(sel10, chan, "sel10");
        chk1(hold12, 1'b0, "hold12");
        chk1(oe12, 1'b0, "oe12");
        chk1(oe10, 1'b0, "oe10");
        u_dca_host_model.end_frame();
    endtask : t_frame

    task automatic test_full_scale();
        t_frame(1'b1, 1'b0, 12'hFFF, 12'h000);
        t_frame(1'b0, 1'b1, 12'hFFF, 12'h000);
        $display("test full_scale done");
    endtask : test_full_scale

    task automatic test_abort();
        analog_input_zero = 12'h123;
        u_dca_host_model.run_frame(1'b1, 6, f12, f10, h10);
        chk1(oe12, 1'b1, "oe before abort");
        chk1(hold12, 1'b1, "hold before abort");
        u_dca_host_model.end_frame();
        chk1(oe12, 1'b0, "oe after abort");
        chk1(hold10, 1'b0, "hold after abort");
        u_dca_host_model.stray_falls();
        chk1(oe10, 1'b0, "oe on stray falls");
        t_frame(1'b0, 1'b0, 12'hA5C, 12'h3A6);
        $display("test abort done");
    endtask : test_abort

    task automatic test_mid_codes();
        t_frame(1'b1, 1'b0, 12'h800, 12'h7FF);
        t_frame(1'b1, 1'b1, 12'h555, 12'h2AA);
        $display("test mid_codes done");
    endtask : test_mid_codes

    initial begin
        failures  = 0;
        cmp_count = 0;
        cycles    = 0;
        reset_n   = 1'b0;
        analog_input_zero = 12'h000;
        analog_input_one  = 12'h000;
        repeat (16) @(negedge ref_clk);
        reset_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        test_full_scale();
        test_abort();
        test_mid_codes();
        summarize();
    end
endmodule : dca_serial_port_bench
